// File: include/pcb_pkg.sv
// Purpose: Shared constants for the bridge configuration header block
// Assumes: Dword-wide configuration access with byte enables
// Notes: Offsets are byte addresses within configuration space
package pcb_pkg;

  // ----------------------------------------
  // Access port geometry
  // ----------------------------------------
  localparam int CFG_AW = 8;
  localparam int CFG_DW = 32;
  localparam int CFG_BEW = 4;
  localparam int DW_IDX_LSB = 2;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_MAKER = 8'h00;
  localparam logic [7:0] OFF_PART = 8'h02;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_STS = 8'h06;
  localparam logic [7:0] OFF_STEP = 8'h08;

  // ----------------------------------------
  // Command register layout
  // ----------------------------------------
  localparam logic [15:0] CMD_RESET = 16'h0007;
  localparam logic [15:0] CMD_FIXED_ONES = 16'h0007;
  localparam logic [15:0] CMD_WR_MASK = 16'h0108;
  localparam int CMD_SERR_EN_BIT = 8;
  localparam int CMD_SPEC_EN_BIT = 3;

  // ----------------------------------------
  // Status register layout
  // ----------------------------------------
  localparam logic [15:0] STS_RESET = 16'h0280;
  localparam logic [15:0] STS_FIXED = 16'h0280;
  localparam int STS_FLAG_LSB = 11;
  localparam int NUM_FLAGS = 4;
  localparam int FLG_TA_SENT = 0;
  localparam int FLG_TA_GOT = 1;
  localparam int FLG_MA = 2;
  localparam int FLG_SERR = 3;

  // ----------------------------------------
  // Special cycle message codes
  // ----------------------------------------
  localparam logic [15:0] MSG_SHUTDOWN = 16'h0000;

  // ----------------------------------------
  // Access sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    PCB_IDLE = 2'b01,
    PCB_RESP = 2'b10
  } pcb_state_t;

endpackage : pcb_pkg

// File: include/pcb_flag_if.sv
// Purpose: Carrier between the header and its sticky flag bank
// Assumes: Same clock on both ends
// Notes: Set and clear are one-cycle pulses per bit
`timescale 1ns/1ps
interface pcb_flag_if #(parameter int N = 4);
  logic [N-1:0] set;
  logic [N-1:0] clr;
  logic [N-1:0] flags;
  modport bank (input set, input clr, output flags);
  modport user (output set, output clr, input flags);
endinterface : pcb_flag_if

// File: hw/pcb_flag_bank.sv
// Purpose: Bank of write-one-to-clear sticky status flags
// Assumes: Set and clear pulses come from sys_clk_i logic
// Notes: A set in the same cycle as a clear wins
`timescale 1ns/1ps
module pcb_flag_bank #(
  parameter int N = 4
) (
  input wire logic sys_clk_i, // System clock
  input wire logic resetn_i,  // Async reset, active low
  pcb_flag_if.bank fl         // Set, clear and flag values
);
  import pcb_pkg::*;

  logic [N-1:0] flag_reg;

  // ----------------------------------------
  // One sticky bit per flag
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_flag
      always_ff @(posedge sys_clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
          flag_reg[g] <= 1'b0;
        else if (fl.set[g])
          flag_reg[g] <= 1'b1;
        else if (fl.clr[g])
          flag_reg[g] <= 1'b0;
      end
    end
  endgenerate

  assign fl.flags = flag_reg;

endmodule : pcb_flag_bank

// File: hw/pcb_config_header.sv
// Purpose: Configuration header registers of the ISA bridge function
// Assumes: Access and event inputs come from sys_clk_i logic
// Notes: Class code and later registers are handled elsewhere
`timescale 1ns/1ps

module pcb_config_header #(
  parameter logic [15:0] MAKER_CODE = 16'h1234, // Arbitrary value
  parameter logic [15:0] PART_CODE = 16'h5678,  // Arbitrary value
  parameter logic [7:0] STEPPING_CODE = 8'hA5   // Arbitrary value
) (
  input wire logic sys_clk_i,                                  // System clock
  input wire logic resetn_i,                                   // Async reset, low
  input wire logic cfg_req_i,                                  // Config access pulse
  input wire logic cfg_wr_i,                                   // 1 write, 0 read
  input wire logic [pcb_pkg::CFG_AW-1:0] cfg_addr_i,           // Byte address
  input wire logic [pcb_pkg::CFG_BEW-1:0] cfg_be_i,            // Byte enables
  input wire logic [pcb_pkg::CFG_DW-1:0] cfg_wdata_i,          // Write data
  output logic cfg_ack_o,                                      // Access done pulse
  output logic [pcb_pkg::CFG_DW-1:0] cfg_rdata_o,              // Read data
  input wire logic dtxn_timeout_i,                             // Timeout pulse
  input wire logic dtxn_serr_en_i,                             // Delayed-txn bit 3
  input wire logic initiator_abort_i,                          // Master-abort pulse
  input wire logic target_abort_got_i,                         // Got target-abort
  input wire logic target_abort_sent_i,                        // Sent target-abort
  input wire logic special_cycle_i,                            // Special cycle pulse
  input wire logic [15:0] special_msg_i,                       // Message code
  output logic system_error_o,                                 // Drive system error
  output logic shutdown_o,                                     // Shutdown seen pulse
  output logic system_error_enable_o,                          // Command bit 8
  output logic special_cycle_enable_o                          // Command bit 3
);
  import pcb_pkg::*;

  // Half of a dword, the width of every register here but stepping
  localparam int HALF_W = CFG_DW / 2;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic dw_hit(
    input logic [CFG_AW-1:0] addr,
    input logic [7:0] off
  );
    dw_hit = (addr[CFG_AW-1:DW_IDX_LSB] == off[CFG_AW-1:DW_IDX_LSB]);
  endfunction : dw_hit

  // Which lane of the dword a half-word at this offset occupies
  function automatic logic hi_half(input logic [7:0] off);
    hi_half = off[1];
  endfunction : hi_half

  // Byte-enable expansion into a per-bit mask for one half-word
  function automatic logic [15:0] half_mask(
    input logic [CFG_BEW-1:0] be,
    input logic hi
  );
    logic [1:0] b;
    b = hi ? be[3:2] : be[1:0];
    half_mask = {{8{b[1]}}, {8{b[0]}}};
  endfunction : half_mask

  function automatic logic [15:0] half_data(
    input logic [CFG_DW-1:0] d,
    input logic hi
  );
    half_data = hi ? d[CFG_DW-1 -: HALF_W] : d[HALF_W-1:0];
  endfunction : half_data

  // Put a half-word into its lane of a dword, the other lane zero
  function automatic logic [CFG_DW-1:0] place_half(
    input logic [15:0] v,
    input logic hi
  );
    place_half = hi ? {v, 16'h0000} : {16'h0000, v};
  endfunction : place_half

  // ----------------------------------------
  // State
  // ----------------------------------------
  pcb_state_t state_reg;
  pcb_state_t state_next;
  logic [15:0] cmd_reg;
  logic [15:0] cmd_next;
  logic [CFG_DW-1:0] rdata_reg;
  logic [CFG_DW-1:0] rdata_next;
  logic serr_reg;
  logic shutdown_reg;
  logic take;
  logic wr_cmd;
  logic wr_sts;
  logic [15:0] wmask;
  logic [15:0] wval;
  logic [15:0] sts_clr_bits;
  logic [15:0] status_view;
  logic [15:0] command_view;
  logic serr_fire;
  logic [15:0] sts_wmask;
  logic [15:0] sts_wval;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [CFG_DW-1:0] id_dword;
  logic [CFG_DW-1:0] ctl_dword;
  logic [CFG_DW-1:0] step_dword;

  pcb_flag_if #(.N(NUM_FLAGS)) flag_if ();

  pcb_flag_bank #(
    .N(NUM_FLAGS)
  ) u_flags (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .fl(flag_if.bank)
  );

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  // Requests arriving during the answer cycle are dropped
  assign take = cfg_req_i && (state_reg == PCB_IDLE);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      PCB_IDLE:
      begin
        if (cfg_req_i)
          state_next = PCB_RESP;
      end
      PCB_RESP:
      begin
        state_next = PCB_IDLE;
      end
      default:
      begin
        state_next = PCB_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state_reg <= PCB_IDLE;
    else
      state_reg <= state_next;
  end

  assign cfg_ack_o = (state_reg == PCB_RESP);

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  // Identity dwords have no write path at all
  assign wr_cmd = take && cfg_wr_i && dw_hit(cfg_addr_i, OFF_CMD);
  assign wr_sts = take && cfg_wr_i && dw_hit(cfg_addr_i, OFF_STS);
  assign wmask = half_mask(cfg_be_i, hi_half(OFF_CMD));
  assign wval = half_data(cfg_wdata_i, hi_half(OFF_CMD));
  assign sts_wmask = half_mask(cfg_be_i, hi_half(OFF_STS));
  assign sts_wval = half_data(cfg_wdata_i, hi_half(OFF_STS));

  // ----------------------------------------
  // Command register
  // ----------------------------------------
  always_comb
  begin
    cmd_next = cmd_reg;
    if (wr_cmd)
      cmd_next = (cmd_reg & ~(wmask & CMD_WR_MASK)) | (wval & wmask & CMD_WR_MASK);
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      cmd_reg <= CMD_RESET;
    else
      cmd_reg <= cmd_next;
  end

  // Only the two enables are storage; the rest is fixed wiring
  assign command_view = (cmd_reg & CMD_WR_MASK) | CMD_FIXED_ONES;

  assign system_error_enable_o = cmd_reg[CMD_SERR_EN_BIT];
  assign special_cycle_enable_o = cmd_reg[CMD_SPEC_EN_BIT];

  // ----------------------------------------
  // System error
  // ----------------------------------------
  assign serr_fire = dtxn_timeout_i && cmd_reg[CMD_SERR_EN_BIT] && dtxn_serr_en_i;

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      serr_reg <= 1'b0;
    else
      serr_reg <= serr_fire;
  end

  assign system_error_o = serr_reg;

  // ----------------------------------------
  // Shutdown recognition
  // ----------------------------------------
  // Disabled means every special cycle is ignored, not only shutdown
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      shutdown_reg <= 1'b0;
    else
      shutdown_reg <= special_cycle_i && cmd_reg[CMD_SPEC_EN_BIT]
        && (special_msg_i == MSG_SHUTDOWN);
  end

  assign shutdown_o = shutdown_reg;

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  // Flag follows the driven pulse, so it never sets without the pin
  // One driver for the whole set vector keeps the carrier single-sourced
  always_comb
  begin
    flag_set = '0;
    flag_set[FLG_SERR] = serr_reg;
    flag_set[FLG_MA] = initiator_abort_i;
    flag_set[FLG_TA_GOT] = target_abort_got_i;
    flag_set[FLG_TA_SENT] = target_abort_sent_i;
  end

  assign flag_if.set = flag_set;

  // Only ones written under an enabled lane clear; zeros leave flags
  assign sts_clr_bits = wr_sts ? (sts_wval & sts_wmask) : 16'h0000;

  assign flag_if.clr = sts_clr_bits[STS_FLAG_LSB +: NUM_FLAGS];

  // ----------------------------------------
  // Status view
  // ----------------------------------------
  always_comb
  begin
    status_view = STS_FIXED;
    status_view[STS_FLAG_LSB +: NUM_FLAGS] = flag_if.flags;
  end

  // ----------------------------------------
  // Dword images
  // ----------------------------------------
  // Each half-word lands in the lane its own offset names, so a
  // moved offset cannot swap two registers silently
  assign id_dword = place_half(MAKER_CODE, hi_half(OFF_MAKER))
    | place_half(PART_CODE, hi_half(OFF_PART));
  assign ctl_dword = place_half(command_view, hi_half(OFF_CMD))
    | place_half(status_view, hi_half(OFF_STS));
  // Only the low byte is stepping; the class-code bytes stay zero
  assign step_dword = CFG_DW'(STEPPING_CODE);

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Unmapped dwords, and the class-code bytes beside stepping, read zero
  always_comb
  begin
    rdata_next = rdata_reg;
    if (take && !cfg_wr_i)
    begin
      rdata_next = '0;
      if (dw_hit(cfg_addr_i, OFF_MAKER))
        rdata_next = id_dword;
      else if (dw_hit(cfg_addr_i, OFF_CMD))
        rdata_next = ctl_dword;
      else if (dw_hit(cfg_addr_i, OFF_STEP))
        rdata_next = step_dword;
    end
    else if (take)
    begin
      rdata_next = '0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rdata_reg <= '0;
    else
      rdata_reg <= rdata_next;
  end

  assign cfg_rdata_o = rdata_reg;

endmodule : pcb_config_header

// File: tb/pcb_config_header_assertions.sv
// Purpose: Port checks for the bridge configuration header
// Assumes: One clock, async active-low reset
// Notes: Reads are checked whatever the byte enables, which these checks do not see
`timescale 1ns/1ps
module pcb_config_header_assertions #(
  parameter logic [15:0] MAKER_CODE = 16'h1234, // Arbitrary value
  parameter logic [15:0] PART_CODE = 16'h5678 // Arbitrary value
) (
  input wire logic sys_clk_i, // Clock
  input wire logic resetn_i, // Reset
  input wire logic cfg_req_i, // Request
  input wire logic cfg_wr_i, // Write
  input wire logic [pcb_pkg::CFG_AW-1:0] cfg_addr_i, // Address
  input wire logic cfg_ack_o, // Done
  input wire logic [pcb_pkg::CFG_DW-1:0] cfg_rdata_o, // Read data
  input wire logic dtxn_timeout_i, // Timeout
  input wire logic dtxn_serr_en_i, // Gate
  input wire logic special_cycle_i, // Special
  input wire logic [15:0] special_msg_i, // Message
  input wire logic system_error_o, // Error
  input wire logic shutdown_o, // Shutdown
  input wire logic system_error_enable_o, // Bit 8
  input wire logic special_cycle_enable_o // Bit 3
);
  import pcb_pkg::*;
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);
  a_fixed_bits: assert property (cfg_ack_o &&
    $past(cfg_req_i && !cfg_wr_i && cfg_addr_i[7:2] == 6'h01)
    |-> (cfg_rdata_o & 32'h87FF_FEF7) == 32'h0280_0007)
    else $error("fixed command or status bits wrong");
  a_id_read: assert property (cfg_ack_o && $past(cfg_req_i && !cfg_wr_i &&
    cfg_addr_i[7:2] == 6'h00) |-> cfg_rdata_o == {PART_CODE, MAKER_CODE})
    else $error("identity codes wrong");
  a_step_upper: assert property (cfg_ack_o && $past(cfg_req_i && !cfg_wr_i &&
    cfg_addr_i[7:2] == 6'h02) |-> cfg_rdata_o[31:8] == 24'h0)
    else $error("stepping dword upper bits set");
  a_serr_fire: assert property (dtxn_timeout_i && dtxn_serr_en_i && system_error_enable_o
    |=> system_error_o) else $error("system error missing");
  a_serr_gate: assert property (system_error_o |->
    $past(dtxn_timeout_i && dtxn_serr_en_i && system_error_enable_o))
    else $error("system error without cause");
  a_shut_fire: assert property (special_cycle_i && special_cycle_enable_o &&
    special_msg_i == MSG_SHUTDOWN |=> shutdown_o) else $error("shutdown missing");
  a_shut_gate: assert property (shutdown_o |->
    $past(special_cycle_i && special_cycle_enable_o && special_msg_i == MSG_SHUTDOWN))
    else $error("shutdown without cause");
  a_enable_write: assert property (
    $changed({system_error_enable_o, special_cycle_enable_o}) |-> cfg_ack_o && $past(cfg_wr_i))
    else $error("enable moved without write");
endmodule : pcb_config_header_assertions

bind pcb_config_header pcb_config_header_assertions #(.MAKER_CODE(MAKER_CODE),
  .PART_CODE(PART_CODE)) pcb_chk_inst (.sys_clk_i, .resetn_i, .cfg_req_i, .cfg_wr_i,
  .cfg_addr_i, .cfg_ack_o, .cfg_rdata_o, .dtxn_timeout_i, .dtxn_serr_en_i, .special_cycle_i,
  .special_msg_i, .system_error_o, .shutdown_o, .system_error_enable_o, .special_cycle_enable_o);

// File: tb/pcb_host_model.sv
// Purpose: Host side issuing configuration accesses
// Assumes: Tasks are entered just after a falling edge
// Notes: Idle lines show inverted values so stale data never looks valid
`timescale 1ns/1ps
module pcb_host_model (
  input wire logic clk_i, // Clock
  input wire logic cfg_ack_i, // Done
  input wire logic [pcb_pkg::CFG_DW-1:0] cfg_rdata_i, // Read data
  output logic cfg_req_o, // Request
  output logic cfg_wr_o, // Write
  output logic [pcb_pkg::CFG_AW-1:0] cfg_addr_o, // Address
  output logic [pcb_pkg::CFG_BEW-1:0] cfg_be_o, // Lanes
  output logic [pcb_pkg::CFG_DW-1:0] cfg_wdata_o // Write data
);
  import pcb_pkg::*;
  int idle = 0;
  initial
  begin
    cfg_req_o = 1'b0;
    cfg_wr_o = 1'b0;
    cfg_addr_o = 8'h00;
    cfg_be_o = 4'h0;
    cfg_wdata_o = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] b,
    input logic [31:0] d, output logic [31:0] q, output logic ok);
    repeat (idle) @(negedge clk_i);
    cfg_req_o = 1'b1;
    cfg_wr_o = w;
    cfg_addr_o = a;
    cfg_be_o = b;
    cfg_wdata_o = d;
    @(negedge clk_i);
    ok = cfg_ack_i;
    q = cfg_rdata_i;
    cfg_req_o = 1'b0;
    cfg_wr_o = ~w;
    cfg_addr_o = ~a;
    cfg_be_o = ~b;
    cfg_wdata_o = ~d;
    // Skip the ack cycle, a request there is dropped
    @(negedge clk_i);
  endtask : xfer
endmodule : pcb_host_model

// File: tb/tb.sv
// Purpose: Register and event tests of the configuration header
// Assumes: Inputs move on the falling edge
// Notes: Identity parameters are arbitrary
`timescale 1ns/1ps
module tb;
  import pcb_pkg::*;
  localparam logic [15:0] MK = 16'h1234; // Arbitrary value
  localparam logic [15:0] PK = 16'h5678; // Arbitrary value
  localparam logic [7:0] SK = 8'h3C; // Arbitrary value
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic req, wr, ack, serr, shut, sen, cen;
  logic en = 1'b0, sc = 1'b0, to = 1'b0, ia = 1'b0, tg = 1'b0, ts = 1'b0;
  logic [7:0] addr;
  logic [3:0] be;
  logic [31:0] wd, rdat, q;
  logic [15:0] msg = 16'hFFFF;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  pcb_host_model pcb_host_model_inst (.clk_i(sys_clk_i), .cfg_ack_i(ack), .cfg_rdata_i(rdat),
    .cfg_req_o(req), .cfg_wr_o(wr), .cfg_addr_o(addr), .cfg_be_o(be), .cfg_wdata_o(wd));
  pcb_config_header #(.MAKER_CODE(MK), .PART_CODE(PK), .STEPPING_CODE(SK))
    pcb_config_header_inst (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cfg_req_i(req),
    .cfg_wr_i(wr), .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wd), .cfg_ack_o(ack),
    .cfg_rdata_o(rdat), .dtxn_timeout_i(to), .dtxn_serr_en_i(en), .initiator_abort_i(ia),
    .target_abort_got_i(tg), .target_abort_sent_i(ts), .special_cycle_i(sc),
    .special_msg_i(msg), .system_error_o(serr), .shutdown_o(shut),
    .system_error_enable_o(sen), .special_cycle_enable_o(cen));
  initial
  begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic xf(input logic w, input logic [7:0] a, input logic [3:0] b,
    input logic [31:0] d, input logic [31:0] e);
    logic ok;
    pcb_host_model_inst.xfer(w, a, b, d, q, ok);
    chk({31'h0, ok}, 32'h1);
    if (!w)
      chk(q, e);
  endtask : xf
  task automatic ev(input logic [4:0] p, input logic [15:0] m, input logic [1:0] e);
    {sc, to, ia, tg, ts} = p;
    msg = m;
    @(negedge sys_clk_i);
    {sc, to, ia, tg, ts} = 5'h00;
    msg = ~m;
    chk({30'h0, serr, shut}, {30'h0, e});
    @(negedge sys_clk_i);
  endtask : ev
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      err_total++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (5) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    @(negedge sys_clk_i);
    xf(0, 8'h04, 4'hF, 0, 32'h0280_0007);
    xf(0, 8'h00, 4'hF, 0, {PK, MK});
    xf(0, 8'h08, 4'hF, 0, {24'h0, SK});
    xf(0, 8'h0C, 4'hF, 0, 32'h0);
    xf(1, 8'h00, 4'hF, 32'hFFFF_FFFF, 0);
    xf(1, 8'h08, 4'hF, 32'hFFFF_FFFF, 0);
    xf(0, 8'h00, 4'hF, 0, {PK, MK});
    xf(0, 8'h08, 4'hF, 0, {24'h0, SK});
    xf(1, 8'h04, 4'hF, 32'h0000_FFFF, 0);
    xf(0, 8'h04, 4'hF, 0, 32'h0280_010F);
    chk({30'h0, sen, cen}, 32'h3);
    $display("Test access done");
    ev(5'h08, 16'h0, 2'b00);
    en = 1'b1;
    ev(5'h08, 16'h0, 2'b10);
    ev(5'h10, MSG_SHUTDOWN, 2'b01);
    ev(5'h10, 16'h0001, 2'b00);
    ev(5'h04, 16'h0, 2'b00);
    xf(0, 8'h04, 4'hF, 0, 32'h6280_010F);
    ev(5'h02, 16'h0, 2'b00);
    xf(0, 8'h04, 4'hF, 0, 32'h7280_010F);
    ev(5'h01, 16'h0, 2'b00);
    xf(0, 8'h04, 4'hF, 0, 32'h7A80_010F);
    xf(1, 8'h04, 4'hC, 32'h0, 0);
    xf(0, 8'h04, 4'hF, 0, 32'h7A80_010F);
    fork
      xf(1, 8'h04, 4'h8, 32'h2000_0000, 0);
      begin
        ia = 1'b1;
        @(negedge sys_clk_i);
        ia = 1'b0;
      end
    join
    xf(0, 8'h04, 4'hF, 0, 32'h7A80_010F);
    pcb_host_model_inst.idle = 2;
    xf(1, 8'h04, 4'h8, 32'h7800_0000, 0);
    xf(0, 8'h04, 4'hF, 0, 32'h0280_010F);
    $display("Test flags done");
    xf(1, 8'h04, 4'h3, 32'h0, 0);
    chk({30'h0, sen, cen}, 32'h0);
    ev(5'h08, 16'h0, 2'b00);
    ev(5'h10, MSG_SHUTDOWN, 2'b00);
    xf(0, 8'h04, 4'hF, 0, 32'h0280_0007);
    $display("Test gating done");
    xf(1, 8'h04, 4'h3, 32'h0000_0108, 0);
    ev(5'h04, 16'h0, 2'b00);
    resetn_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    resetn_i = 1'b1;
    @(negedge sys_clk_i);
    chk({29'h0, ack, sen, cen}, 32'h0);
    xf(0, 8'h04, 4'hF, 0, 32'h0280_0007);
    $display("Test reset done");
    wrap_up();
  end
endmodule : tb
